// >>> shared/pmc_defs.svh
// constants, offsets and field positions of the power mode controller
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH
// What this block does
// - power state follows primary enable, wake pin and control register mode bits
// - sleep keeps digital supply and 60 kHz clock only, radio and fast clock off
// - primary enable high turns on regulators, oscillator and system clock output
// - wake rising edge in power-down starts up as if primary enable rose
// - start-up lasts until supplies settle and oscillator is stable, then active with primary enable, else a confirm wait
// - without primary enable 100 us after clock switch, fall back to power-down
// - when settled and stable, system clock switches from 60 kHz to crystal clock
// - oscillator-stable flag, bit 6 of oscillator status, is set at that switch
// - standby bit 7 turns transmitter and receiver off, keeps fast clock running
// - bits 5 and 1 clear select mode 1 with the whole radio off
// - bit 1 set with bit 5 clear powers only the receiver
// - bit 5 set powers transmitter and receiver for normal operation
// - bit 4 set with bit 5 selects half output power, clear selects full
// - bit 0 selects 5 V supply when set, the default, 3 V when clear
`define CSC_IDX        6'h00
`define REG_IDX        6'h0B
`define OSC_IDX        6'h0F
`define IRQ_STS_IDX    6'h10
`define IRQ_MSK_IDX    6'h11
`define CSC_RESET      8'h01
`define REG_RESET      8'h80
`define MSK_RESET      3'h0
`define CSC_STBY       7
`define CSC_TXRX       5
`define CSC_HALF       4
`define CSC_RXONLY     1
`define CSC_V5         0
`define OSC_OK_BIT     6
`define EV_OSC         0
`define EV_TMO         1
`define EV_WAKE        2
`define EV_W           3
`define PIN_EN         0
`define PIN_WAKE       1
`define PIN_SETTLED    2
`define PIN_STABLE     3
`define SYNC_W         4
`define CNT_W          12
`define CONFIRM_US     100
`define CLK_PERIOD_NS  40
`define NS_PER_US      1000
`define CONFIRM_CYC    ((`CONFIRM_US * `NS_PER_US) / `CLK_PERIOD_NS)
`endif

// >>> shared/pmc_pkg.sv
// types of the power mode controller
`include "pmc_defs.svh"
package pmc_pkg;
    typedef enum logic [2:0] {
        ST_OFF,
        ST_SLEEP,
        ST_STARTUP,
        ST_CONFIRM,
        ST_ACTIVE
    } pwr_state_e;

    typedef struct packed {
        logic reg_en;
        logic osc_en;
        logic dsup;
        logic aux;
        logic hf;
        logic tx;
        logic rx;
        logic half;
        logic v5;
    } drive_s;

    typedef struct packed {
        pwr_state_e         st;
        logic               wstart;
        logic               wake_q;
        logic [`CNT_W-1:0]  cnt;
        logic               osc_ok;
        logic [7:0]         csc;
        logic [7:0]         regc;
        logic [`EV_W-1:0]   sts;
        logic [`EV_W-1:0]   msk;
        logic [31:0]        rdata;
        logic               err;
        drive_s             drv;
    } pmc_s;
endpackage

// >>> shared/pin_sync_if.sv
// raw pin levels in, filtered levels out
`timescale 1ns/10ps
interface pin_sync_if #(
    parameter int W = 4
);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface

// >>> logic/pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync #(
    parameter int W = 4
) (
    input  wire logic pclk,
    input  wire logic presetn,
    pin_sync_if.sync  port
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } sync_s;

    sync_s cur_ff;
    sync_s nxt_sync;
    logic [W-1:0] agree;

    always_comb begin
        nxt_sync = cur_ff;
        nxt_sync.s1 = port.raw;
        nxt_sync.s2 = cur_ff.s1;
        nxt_sync.s3 = cur_ff.s2;
        // a level counts once stages two and three agree
        agree = ~(cur_ff.s2 ^ cur_ff.s3);
        nxt_sync.q = (cur_ff.s3 & agree) | (cur_ff.q & ~agree);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_sync;
        end
    end

    assign port.clean = cur_ff.q;
endmodule

// >>> logic/pmc_top.sv
// power mode controller with apb register access
`timescale 1ns/10ps
`include "pmc_defs.svh"
module pmc_top #(
    parameter int unsigned CONFIRM_CYC = `CONFIRM_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output      logic [31:0] prdata,
    output      logic        pready,
    output      logic        pslverr,
    input  wire logic        primary_enable,
    input  wire logic        secondary_wake_input,
    input  wire logic        regulators_settled,
    input  wire logic        oscillator_stable,
    output      logic        regulator_enable,
    output      logic        oscillator_enable,
    output      logic        digital_supply_output,
    output      logic        aux_clock_enable,
    output      logic        hf_clock_enable,
    output      logic        transmitter_enable,
    output      logic        receiver_enable,
    output      logic        half_power,
    output      logic        supply_5v_select,
    output      logic [7:0]  regulation_setting,
    output      logic        osc_ok,
    output      logic        irq
);
    import pmc_pkg::*;

    pmc_s              cur_ff;
    pmc_s              nxt_pmc;
    logic              en_s;
    logic              wake_s;
    logic              rdy_s;
    logic              wake_rise;
    logic              setup;
    logic              wr;
    logic              rd_sts;
    logic [`EV_W-1:0]  ev;
    logic [5:0]        widx;
    logic [5:0]        ridx;

    pin_sync_if #(.W(`SYNC_W)) sp ();

    assign sp.raw[`PIN_EN]      = primary_enable;
    assign sp.raw[`PIN_WAKE]    = secondary_wake_input;
    assign sp.raw[`PIN_SETTLED] = regulators_settled;
    assign sp.raw[`PIN_STABLE]  = oscillator_stable;

    pin_sync #(.W(`SYNC_W)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .port    (sp)
    );

    assign en_s   = sp.clean[`PIN_EN];
    assign wake_s = sp.clean[`PIN_WAKE];
    assign rdy_s  = sp.clean[`PIN_SETTLED] & sp.clean[`PIN_STABLE];
    assign widx   = paddr[7:2];
    assign ridx   = paddr[7:2];

    always_comb begin
        nxt_pmc = cur_ff;
        ev = '0;
        setup = psel & ~penable;
        wr = psel & penable & pwrite;
        rd_sts = psel & penable & ~pwrite & (ridx == `IRQ_STS_IDX);
        nxt_pmc.wake_q = wake_s;
        wake_rise = wake_s & ~cur_ff.wake_q;

        // power state sequencing
        case (cur_ff.st)
            ST_OFF: begin
                if (en_s) begin
                    nxt_pmc.st = ST_STARTUP;
                    nxt_pmc.wstart = 1'b0;
                end else if (wake_rise) begin
                    nxt_pmc.st = ST_STARTUP;
                    nxt_pmc.wstart = 1'b1;
                    ev[`EV_WAKE] = 1'b1;
                end
            end
            ST_SLEEP: begin
                if (en_s) begin
                    nxt_pmc.st = ST_STARTUP;
                    nxt_pmc.wstart = 1'b0;
                end else if (!wake_s) begin
                    nxt_pmc.st = ST_OFF;
                end
            end
            ST_STARTUP: begin
                if (!en_s && !cur_ff.wstart) begin
                    nxt_pmc.st = wake_s ? ST_SLEEP : ST_OFF;
                end else if (rdy_s) begin
                    nxt_pmc.osc_ok = 1'b1;
                    ev[`EV_OSC] = 1'b1;
                    nxt_pmc.cnt = '0;
                    nxt_pmc.st = en_s ? ST_ACTIVE : ST_CONFIRM;
                end
            end
            ST_CONFIRM: begin
                if (en_s) begin
                    nxt_pmc.st = ST_ACTIVE;
                end else if (cur_ff.cnt == `CNT_W'(CONFIRM_CYC - 1)) begin
                    nxt_pmc.st = ST_OFF;
                    ev[`EV_TMO] = 1'b1;
                end else begin
                    nxt_pmc.cnt = cur_ff.cnt + `CNT_W'(1);
                end
            end
            ST_ACTIVE: begin
                if (!en_s) begin
                    nxt_pmc.st = wake_s ? ST_SLEEP : ST_OFF;
                end
            end
            default: begin
                nxt_pmc.st = ST_OFF;
            end
        endcase
        if (nxt_pmc.st == ST_OFF || nxt_pmc.st == ST_SLEEP) begin
            nxt_pmc.osc_ok = 1'b0;
        end

        // register writes take effect in the access phase
        if (wr) begin
            case (widx)
                `CSC_IDX:     nxt_pmc.csc = pwdata[7:0];
                `REG_IDX:     nxt_pmc.regc = pwdata[7:0];
                `IRQ_MSK_IDX: nxt_pmc.msk = pwdata[`EV_W-1:0];
                default:      nxt_pmc.csc = cur_ff.csc;
            endcase
        end

        // read clears only the bits it returned, a new event wins
        nxt_pmc.sts = (cur_ff.sts & ~({`EV_W{rd_sts}} & cur_ff.rdata[`EV_W-1:0])) | ev;

        // read data and error captured during the setup phase
        if (setup) begin
            nxt_pmc.rdata = '0;
            nxt_pmc.err = 1'b0;
            case (ridx)
                `CSC_IDX:     nxt_pmc.rdata[7:0] = cur_ff.csc;
                `REG_IDX:     nxt_pmc.rdata[7:0] = cur_ff.regc;
                `OSC_IDX:     nxt_pmc.rdata[`OSC_OK_BIT] = cur_ff.osc_ok;
                `IRQ_STS_IDX: nxt_pmc.rdata[`EV_W-1:0] = cur_ff.sts;
                `IRQ_MSK_IDX: nxt_pmc.rdata[`EV_W-1:0] = cur_ff.msk;
                default:      nxt_pmc.err = 1'b1;
            endcase
        end

        // output drive follows the next state and the mode bits
        nxt_pmc.drv = '0;
        case (nxt_pmc.st)
            ST_SLEEP: begin
                nxt_pmc.drv.dsup = 1'b1;
                nxt_pmc.drv.aux = 1'b1;
                nxt_pmc.drv.v5 = nxt_pmc.csc[`CSC_V5];
            end
            ST_STARTUP: begin
                nxt_pmc.drv.reg_en = 1'b1;
                nxt_pmc.drv.osc_en = 1'b1;
                nxt_pmc.drv.dsup = 1'b1;
                nxt_pmc.drv.aux = 1'b1;
                nxt_pmc.drv.v5 = nxt_pmc.csc[`CSC_V5];
            end
            ST_CONFIRM, ST_ACTIVE: begin
                nxt_pmc.drv.reg_en = 1'b1;
                nxt_pmc.drv.osc_en = 1'b1;
                nxt_pmc.drv.dsup = 1'b1;
                nxt_pmc.drv.hf = 1'b1;
                nxt_pmc.drv.v5 = nxt_pmc.csc[`CSC_V5];
                if (nxt_pmc.st == ST_ACTIVE && !nxt_pmc.csc[`CSC_STBY]) begin
                    if (nxt_pmc.csc[`CSC_TXRX]) begin
                        nxt_pmc.drv.tx = 1'b1;
                        nxt_pmc.drv.rx = 1'b1;
                        nxt_pmc.drv.half = nxt_pmc.csc[`CSC_HALF];
                    end else if (nxt_pmc.csc[`CSC_RXONLY]) begin
                        nxt_pmc.drv.rx = 1'b1;
                    end
                end
            end
            default: begin
                nxt_pmc.drv = '0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_ff <= '0;
            cur_ff.st <= ST_OFF;
            cur_ff.csc <= `CSC_RESET;
            cur_ff.regc <= `REG_RESET;
            cur_ff.msk <= `MSK_RESET;
        end else begin
            cur_ff <= nxt_pmc;
        end
    end

    assign prdata                = cur_ff.rdata;
    assign pready                = 1'b1;
    assign pslverr               = cur_ff.err & psel & penable;
    assign regulator_enable      = cur_ff.drv.reg_en;
    assign oscillator_enable     = cur_ff.drv.osc_en;
    assign digital_supply_output = cur_ff.drv.dsup;
    assign aux_clock_enable      = cur_ff.drv.aux;
    assign hf_clock_enable       = cur_ff.drv.hf;
    assign transmitter_enable    = cur_ff.drv.tx;
    assign receiver_enable       = cur_ff.drv.rx;
    assign half_power            = cur_ff.drv.half;
    assign supply_5v_select      = cur_ff.drv.v5;
    assign regulation_setting    = cur_ff.regc;
    assign osc_ok                = cur_ff.osc_ok;
    assign irq                   = |(cur_ff.sts & cur_ff.msk);

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_off_all_dark: assert property (
        cur_ff.st == ST_OFF |-> !digital_supply_output && !aux_clock_enable &&
            !hf_clock_enable && !transmitter_enable && !receiver_enable && !supply_5v_select)
        else $error("power-down leaves an output on");

    chk_sleep_aux_only: assert property (
        cur_ff.st == ST_SLEEP |-> digital_supply_output && aux_clock_enable &&
            !hf_clock_enable && !transmitter_enable && !receiver_enable)
        else $error("sleep drive wrong");

    chk_enable_starts: assert property (
        cur_ff.st == ST_OFF && en_s |=> cur_ff.st == ST_STARTUP ##0
            regulator_enable && oscillator_enable)
        else $error("primary enable did not start supplies");

    chk_wake_edge: assert property (
        cur_ff.st == ST_OFF && !en_s && wake_s && !cur_ff.wake_q
            |=> cur_ff.st == ST_STARTUP && oscillator_enable)
        else $error("wake edge did not start up");

    chk_startup_hold: assert property (
        cur_ff.st == ST_STARTUP && !rdy_s && (en_s || cur_ff.wstart)
            |=> cur_ff.st == ST_STARTUP)
        else $error("start-up left before ready");

    chk_startup_done: assert property (
        cur_ff.st == ST_STARTUP && rdy_s && en_s |=> cur_ff.st == ST_ACTIVE)
        else $error("start-up did not reach active");

    chk_confirm_limit: assert property (
        cur_ff.st == ST_CONFIRM && !en_s && cur_ff.cnt == `CNT_W'(CONFIRM_CYC - 1)
            |=> cur_ff.st == ST_OFF)
        else $error("confirm window did not expire");

    chk_confirm_count: assert property (
        cur_ff.st == ST_CONFIRM |-> cur_ff.cnt < `CNT_W'(CONFIRM_CYC))
        else $error("confirm counter overran");

    chk_clock_switch: assert property (
        cur_ff.st == ST_STARTUP && rdy_s && (en_s || cur_ff.wstart)
            |=> hf_clock_enable && !aux_clock_enable)
        else $error("clock did not switch");

    chk_osc_flag: assert property (
        $rose(osc_ok) |-> $past(cur_ff.st) == ST_STARTUP && hf_clock_enable)
        else $error("oscillator flag set at wrong moment");

    chk_standby_mode: assert property (
        cur_ff.st == ST_ACTIVE && cur_ff.csc[`CSC_STBY]
            |-> !transmitter_enable && !receiver_enable && hf_clock_enable)
        else $error("standby drive wrong");

    chk_mode1_off: assert property (
        cur_ff.st == ST_ACTIVE && !cur_ff.csc[`CSC_TXRX] && !cur_ff.csc[`CSC_RXONLY]
            |-> !transmitter_enable && !receiver_enable)
        else $error("mode 1 radio not off");

    chk_mode2_rx: assert property (
        cur_ff.st == ST_ACTIVE && !cur_ff.csc[`CSC_STBY] && !cur_ff.csc[`CSC_TXRX] &&
            cur_ff.csc[`CSC_RXONLY] |-> receiver_enable && !transmitter_enable)
        else $error("mode 2 drive wrong");

    chk_mode34_full: assert property (
        cur_ff.st == ST_ACTIVE && !cur_ff.csc[`CSC_STBY] && cur_ff.csc[`CSC_TXRX]
            |-> receiver_enable && transmitter_enable &&
            half_power == cur_ff.csc[`CSC_HALF])
        else $error("transmit mode drive wrong");

    chk_supply_sel: assert property (
        cur_ff.st != ST_OFF |-> supply_5v_select == cur_ff.csc[`CSC_V5])
        else $error("supply select wrong");

    chk_irq_clear: assert property (
        rd_sts |=> cur_ff.sts == ($past(cur_ff.sts & ~cur_ff.rdata[`EV_W-1:0]) | $past(ev)))
        else $error("status not cleared by read");

    cov_sleep: cover property (cur_ff.st == ST_ACTIVE ##1 cur_ff.st == ST_SLEEP);
    cov_timeout: cover property (cur_ff.st == ST_CONFIRM ##1 cur_ff.st == ST_OFF);
    cov_full_power: cover property (transmitter_enable && !half_power);
    cov_wake_active: cover property (cur_ff.wstart && cur_ff.st == ST_ACTIVE);
endmodule

// >>> dv/analog_model.sv
// supply and oscillator stand-in behind the power mode controller
`timescale 1ns/10ps
module analog_model #(
    parameter int SETTLE = 6
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic regulator_enable,
    input  wire logic oscillator_enable,
    output      logic regulators_settled,
    output      logic oscillator_stable
);
    int cnt_ff;
    // ready flags rise only after both enables stay up for SETTLE cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 0;
        end else if (!(regulator_enable && oscillator_enable)) begin
            cnt_ff <= 0;
        end else if (cnt_ff < SETTLE) begin
            cnt_ff <= cnt_ff + 1;
        end
    end
    assign regulators_settled = (cnt_ff >= SETTLE);
    assign oscillator_stable  = (cnt_ff >= SETTLE);
endmodule

// >>> dv/testbench.sv
// self-checking bench of the power mode controller
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
    $display("wrong value at %0t: %0h vs %0h", $time, a, b); end end
`define WAITC(c) for (int k = 0; k < 400 && !(c); k++) tick(1);
module testbench;
    localparam int CONF     = 20;
    localparam int HOST_GAP = 25000;
    logic        pclk, presetn, psel, penable, pwrite;
    logic        primary_enable, secondary_wake_input;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, err_q, osc_ok, irq;
    logic        reg_en, osc_en, dsup, aux, hf, tx, rx, half, v5, settled, stable;
    logic [8:0]  outs;
    logic [7:0]  regset;
    int          fails, checked;
    assign outs = {reg_en, osc_en, dsup, aux, hf, tx, rx, half, v5};
    pmc_top #(.CONFIRM_CYC(CONF)) pmc_top_i (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .primary_enable(primary_enable),
        .secondary_wake_input(secondary_wake_input), .regulators_settled(settled),
        .oscillator_stable(stable), .regulator_enable(reg_en), .oscillator_enable(osc_en),
        .digital_supply_output(dsup), .aux_clock_enable(aux), .hf_clock_enable(hf),
        .transmitter_enable(tx), .receiver_enable(rx), .half_power(half),
        .supply_5v_select(v5), .regulation_setting(regset), .osc_ok(osc_ok), .irq(irq));
    analog_model analog_model_i (
        .pclk(pclk), .presetn(presetn), .regulator_enable(reg_en),
        .oscillator_enable(osc_en), .regulators_settled(settled), .oscillator_stable(stable));
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        paddr <= a; pwrite <= w; pwdata <= d; psel <= 1'b1; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err_q = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic complete_run;
        if (fails == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic t_reset;
        apb(8'h00, 1'b0, 32'h0); `CHK(q, 32'h0000_0001)
        apb(8'h2C, 1'b0, 32'h0); `CHK(q, 32'h0000_0080)
        apb(8'h80, 1'b0, 32'h0); `CHK({err_q, q}, 33'h1_0000_0000)
        apb(8'h3C, 1'b1, 32'hFF); `CHK(err_q, 1'b0)
        apb(8'h3C, 1'b0, 32'h0); `CHK(q, 32'h0)
        tick(1); `CHK({outs, irq}, 10'h000)
        `CHK(regset, 8'h80)
    endtask
    task automatic t_en_start;
        @(posedge pclk);
        primary_enable <= 1'b1;
        `WAITC(reg_en === 1'b1) `CHK(outs[8:4], 5'h1E)
        `WAITC(osc_ok === 1'b1) `CHK(outs, 9'h1D1)
        apb(8'h3C, 1'b0, 32'h0); `CHK(q[6], 1'b1)
        tick(1); `CHK(irq, 1'b0)
        apb(8'h44, 1'b1, 32'h7); tick(2); `CHK(irq, 1'b1)
        apb(8'h40, 1'b0, 32'h0); `CHK(q, 32'h1)
        tick(2); `CHK(irq, 1'b0)
        apb(8'h2C, 1'b1, 32'h07);
        tick(1); `CHK(regset, 8'h07)
        apb(8'h2C, 1'b0, 32'h0); `CHK(q, 32'h7)
    endtask
    task automatic t_modes;
        logic [7:0] ctl [10] = '{8'h80, 8'h81, 8'h00, 8'h01, 8'h02, 8'h03,
                                 8'h30, 8'h31, 8'h20, 8'h21};
        logic [4:0] exp [10] = '{5'h10, 5'h11, 5'h10, 5'h11, 5'h14, 5'h15,
                                 5'h1E, 5'h1F, 5'h1C, 5'h1D};
        for (int i = 0; i < 10; i++) begin
            apb(8'h00, 1'b1, {24'h0, ctl[i]});
            apb(8'h00, 1'b0, 32'h0); `CHK(q[7:0], ctl[i])
            tick(1); `CHK(outs[4:0], exp[i])
        end
    endtask
    task automatic t_sleep;
        @(posedge pclk);
        secondary_wake_input <= 1'b1;
        tick(HOST_GAP);
        @(posedge pclk);
        primary_enable <= 1'b0;
        `WAITC(hf === 1'b0) tick(2); `CHK({outs[6:1], osc_ok}, 7'h60)
        tick(HOST_GAP);
        @(posedge pclk);
        secondary_wake_input <= 1'b0;
        `WAITC(dsup === 1'b0) tick(2); `CHK(outs, 9'h000)
    endtask
    task automatic t_wake_timeout;
        int n;
        @(posedge pclk);
        secondary_wake_input <= 1'b1;
        `WAITC(reg_en === 1'b1) `CHK(outs[8:5], 4'hF)
        `WAITC(osc_ok === 1'b1) `CHK(hf, 1'b1)
        n = 0;
        while (osc_ok === 1'b1 && n < 200) begin tick(1); n++; end
        `CHK(n, CONF)
        tick(10); `CHK(outs, 9'h000)
        `CHK(irq, 1'b1)
        apb(8'h40, 1'b0, 32'h0); `CHK(q, 32'h7)
        @(posedge pclk);
        secondary_wake_input <= 1'b0;
        tick(5);
    endtask
    task automatic t_wake_confirm;
        @(posedge pclk);
        secondary_wake_input <= 1'b1;
        `WAITC(osc_ok === 1'b1)
        @(posedge pclk);
        primary_enable <= 1'b1;
        tick(CONF + 10); `CHK({hf, reg_en, osc_ok}, 3'h7)
        apb(8'h40, 1'b0, 32'h0); `CHK(q, 32'h5)
    endtask
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        #(40 * 60000);
        fails++;
        complete_run();
    end
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; primary_enable = 1'b0;
        secondary_wake_input = 1'b0; fails = 0; checked = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_en_start();
        t_modes();
        t_sleep();
        t_wake_timeout();
        t_wake_confirm();
        complete_run();
    end
endmodule
